// ===== pkg/rgbfd_consts.svh
/*
  Constants of the RGB fade and mode control core: register map, field
  positions, mode codes and timing. Assumes a 10 MHz system clock.
*/
`ifndef RGBFD_CONSTS_SVH
`define RGBFD_CONSTS_SVH

`define RGBFD_ADDR_CTRL      8'h02
`define RGBFD_ADDR_COL0      8'h03
`define RGBFD_ADDR_COL_LAST  8'h08
`define RGBFD_ADDR_SEL0      8'h09
`define RGBFD_ADDR_SEL_LAST  8'h0C

`define RGBFD_CTRL_RESET     8'h00
`define RGBFD_COL_RESET      8'h00
`define RGBFD_SEL_RESET      8'h00
`define RGBFD_MODE_HI        7
`define RGBFD_MODE_LO        6
`define RGBFD_DSE_BIT        5
`define RGBFD_TEMP_HI        4
`define RGBFD_TEMP_LO        3
`define RGBFD_RATE_HI        2
`define RGBFD_RATE_LO        0

`define RGBFD_MODE_OFF       2'h0
`define RGBFD_MODE_NIGHT     2'h1
`define RGBFD_MODE_NORMAL    2'h2
`define RGBFD_MODE_RESET     2'h3

`define RGBFD_CLK_MHZ        10
`define RGBFD_SLOT_NS        10900
`define RGBFD_SLOT_CYC       ((`RGBFD_SLOT_NS * `RGBFD_CLK_MHZ) / 1000)
`define RGBFD_TAU_MIN_US     31250
`define RGBFD_FADE_SHIFT     6
`define RGBFD_TICK_BASE_CYC  ((`RGBFD_TAU_MIN_US * `RGBFD_CLK_MHZ) >> `RGBFD_FADE_SHIFT)
`define RGBFD_SCALE_STEP_US  400
`define RGBFD_SCALE_STEP_CYC (`RGBFD_SCALE_STEP_US * `RGBFD_CLK_MHZ)
`define RGBFD_SCALE_FULL     7'h40
`define RGBFD_SCALE_MIN      7'h10
`define RGBFD_FRAC_BITS      8

`endif

// ===== pkg/rgbfd_pkg.sv
/*
  Types of the RGB fade and mode control core.
  Assumes the constants header is compiled alongside.
*/
package rgbfd_pkg;
    typedef enum logic [3:0] {
        ST_STANDBY = 4'h1,
        ST_NORMAL  = 4'h2,
        ST_NIGHT   = 4'h4,
        ST_OFFREQ  = 4'h8
    } rgbfd_state_e;

    typedef logic [19:0] rgbfd_level_t;
endpackage : rgbfd_pkg

// ===== hdl/rgbfd_core.sv
/*
  Mode state machine, 24 exponential fade engines, global current scaling
  and four-slot output multiplexing of a 24-channel RGB LED driver.
  Assumes a register write/read port fed by an external serial slave,
  synchronous status inputs from the analog sinks, and a 10 MHz clock.
*/
`timescale 1ns/100ps
`include "rgbfd_consts.svh"

module rgbfd_core
    import rgbfd_pkg::*;
#(
    parameter logic [19:0] P_TICK_BASE = 20'(`RGBFD_TICK_BASE_CYC)
) (
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_nrst,
    // register port
    input  wire logic        i_reg_wr,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    output logic      [7:0]  o_reg_rdata,
    // analog status
    input  wire logic        i_dropout,
    input  wire logic [3:0]  i_temp_over,
    // sink drive
    output logic      [7:0]  o_wire_en,
    output logic      [71:0] o_sink_level,
    output logic      [6:0]  o_scale,
    output logic             o_standby
);

    logic rst_meta_reg;
    logic rst_sync_reg;
    wire  rst_n = rst_sync_reg;

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // registers
    logic [7:0]   ctrl_reg;
    logic [7:0]   color_reg [6];
    logic [7:0]   sel_reg   [4];
    rgbfd_state_e state_reg;
    rgbfd_state_e state_next;
    rgbfd_level_t level_reg [24];
    logic [19:0]  tick_cnt_reg;
    logic [12:0]  scl_cnt_reg;
    logic [6:0]   scale_reg;
    logic [6:0]   scale_next;
    logic [6:0]   slot_cnt_reg;
    logic [1:0]   slot_reg;

    wire       wr_ctrl   = i_reg_wr && (i_reg_addr == `RGBFD_ADDR_CTRL);
    wire [1:0] wr_mode   = i_reg_wdata[`RGBFD_MODE_HI:`RGBFD_MODE_LO];
    wire       reg_clear = wr_ctrl && (wr_mode == `RGBFD_MODE_RESET);
    wire [1:0] mode      = ctrl_reg[`RGBFD_MODE_HI:`RGBFD_MODE_LO];
    wire       dse       = ctrl_reg[`RGBFD_DSE_BIT];
    wire [1:0] temp_sel  = ctrl_reg[`RGBFD_TEMP_HI:`RGBFD_TEMP_LO];
    wire [2:0] rate      = ctrl_reg[`RGBFD_RATE_HI:`RGBFD_RATE_LO];
    wire [7:0] col_off   = i_reg_addr - `RGBFD_ADDR_COL0;
    wire [7:0] sel_off   = i_reg_addr - `RGBFD_ADDR_SEL0;
    wire       in_col    = (i_reg_addr >= `RGBFD_ADDR_COL0) && (i_reg_addr <= `RGBFD_ADDR_COL_LAST);
    wire       in_sel    = (i_reg_addr >= `RGBFD_ADDR_SEL0) && (i_reg_addr <= `RGBFD_ADDR_SEL_LAST);

    // control register; a reset write leaves it all zero
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `RGBFD_CTRL_RESET;
        end else if (reg_clear) begin
            ctrl_reg <= `RGBFD_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= i_reg_wdata;
        end
    end

    // colour and selection registers stay writable in every state
    genvar gk;
    generate
        for (gk = 0; gk < 6; gk++) begin : g_col
            wire wr_col = i_reg_wr && in_col && (col_off[2:0] == 3'(gk));
            always_ff @(posedge i_clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    color_reg[gk] <= `RGBFD_COL_RESET;
                end else if (reg_clear) begin
                    color_reg[gk] <= `RGBFD_COL_RESET;
                end else if (wr_col) begin
                    color_reg[gk] <= i_reg_wdata;
                end
            end
        end
        for (gk = 0; gk < 4; gk++) begin : g_sel
            wire wr_sel = i_reg_wr && in_sel && (sel_off[1:0] == 2'(gk));
            always_ff @(posedge i_clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    sel_reg[gk] <= `RGBFD_SEL_RESET;
                end else if (reg_clear) begin
                    sel_reg[gk] <= `RGBFD_SEL_RESET;
                end else if (wr_sel) begin
                    sel_reg[gk] <= i_reg_wdata;
                end
            end
        end
    endgenerate

    // read data, registered; unmapped addresses read zero
    wire [7:0] rdata_next = (i_reg_addr == `RGBFD_ADDR_CTRL) ? ctrl_reg :
                            in_col ? color_reg[col_off[2:0]] :
                            in_sel ? sel_reg[sel_off[1:0]] : 8'h00;

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_reg_rdata <= 8'h00;
        end else begin
            o_reg_rdata <= rdata_next;
        end
    end

    // mode state machine
    logic [23:0] nonzero;
    wire         all_zero = ~|nonzero;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_STANDBY: begin
                if (mode == `RGBFD_MODE_NORMAL) begin
                    state_next = ST_NORMAL;
                end else if (mode == `RGBFD_MODE_NIGHT) begin
                    state_next = ST_NIGHT;
                end
            end
            ST_NORMAL, ST_NIGHT: begin
                if (mode == `RGBFD_MODE_NORMAL) begin
                    state_next = ST_NORMAL;
                end else if (mode == `RGBFD_MODE_NIGHT) begin
                    state_next = ST_NIGHT;
                end else begin
                    state_next = ST_OFFREQ;
                end
            end
            ST_OFFREQ: begin
                if (mode == `RGBFD_MODE_NORMAL) begin
                    state_next = ST_NORMAL;
                end else if (mode == `RGBFD_MODE_NIGHT) begin
                    state_next = ST_NIGHT;
                end else if (all_zero) begin
                    state_next = ST_STANDBY;
                end
            end
            default: state_next = ST_STANDBY;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_STANDBY;
        end else begin
            state_reg <= state_next;
        end
    end

    wire running = (state_reg == ST_NORMAL) || (state_reg == ST_NIGHT);
    wire night   = (state_reg == ST_NIGHT);
    wire standby = (state_reg == ST_STANDBY);

    // shared fade tick: period doubles per rate step, giving octave-spaced constants
    wire [19:0] tick_lim  = P_TICK_BASE << rate;
    wire        fade_tick = (tick_cnt_reg >= tick_lim - 20'h00001);

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_reg <= 20'h00000;
        end else if (fade_tick) begin
            tick_cnt_reg <= 20'h00000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 20'h00001;
        end
    end

    // global scale: outside standby one step per interval, down under stress, up otherwise; standby forces full scale
    wire stress   = (dse && i_dropout) || i_temp_over[temp_sel];
    wire scl_tick = (scl_cnt_reg == 13'(`RGBFD_SCALE_STEP_CYC - 1));

    // dropout only shows while a lit slot is active, so stress is gathered over the whole interval
    logic stress_seen_reg;
    wire  stress_any = stress || stress_seen_reg;

    always_comb begin
        scale_next = scale_reg;
        if (standby) begin
            scale_next = `RGBFD_SCALE_FULL;
        end else if (scl_tick && stress_any && (scale_reg > `RGBFD_SCALE_MIN)) begin
            scale_next = scale_reg - 7'h01;
        end else if (scl_tick && !stress_any && (scale_reg < `RGBFD_SCALE_FULL)) begin
            scale_next = scale_reg + 7'h01;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            scl_cnt_reg     <= 13'h0000;
            scale_reg       <= `RGBFD_SCALE_FULL;
            stress_seen_reg <= 1'b0;
        end else begin
            scl_cnt_reg     <= scl_tick ? 13'h0000 : scl_cnt_reg + 13'h0001;
            scale_reg       <= scale_next;
            stress_seen_reg <= (scl_tick || standby) ? 1'b0 : stress_any;
        end
    end

    // fade engines; a tiny remainder still moves one fraction step so every ramp lands exactly
    genvar gi;
    generate
        for (gi = 0; gi < 24; gi++) begin : g_fade
            localparam int MOD  = gi / 3;
            localparam int COMP = gi % 3;
            wire [7:0]  nib      = sel_reg[MOD / 2];
            wire [3:0]  sel      = (MOD % 2 == 0) ? nib[7:4] : nib[3:0];
            wire        on       = sel[3] && running;
            wire        pick     = sel[2 - COMP];
            wire [7:0]  code     = pick ? color_reg[3 + COMP] : color_reg[COMP];
            wire [11:0] base     = night ? {4'h0, code} : {code, 4'h0};
            wire [18:0] prod     = base * scale_reg;
            wire [11:0] target   = on ? prod[17:6] : 12'h000;
            wire [20:0] diff     = {1'b0, target, 8'h00} - {1'b0, level_reg[gi]};
            wire [20:0] shifted  = 21'($signed(diff) >>> `RGBFD_FADE_SHIFT);
            wire        tiny     = (shifted == 21'h000000) && (diff != 21'h000000);
            wire [20:0] step     = tiny ? (diff[20] ? 21'h1FFFFF : 21'h000001) : shifted;
            wire [19:0] lvl_next = level_reg[gi] + step[19:0];

            assign nonzero[gi] = |level_reg[gi];

            always_ff @(posedge i_clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    level_reg[gi] <= 20'h00000;
                end else if (fade_tick) begin
                    level_reg[gi] <= lvl_next;
                end
            end
        end
    endgenerate

    // multiplexer slot timing
    wire slot_end = (slot_cnt_reg == 7'(`RGBFD_SLOT_CYC - 1));

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            slot_cnt_reg <= 7'h00;
            slot_reg     <= 2'h0;
        end else begin
            slot_cnt_reg <= slot_end ? 7'h00 : slot_cnt_reg + 7'h01;
            slot_reg     <= slot_end ? slot_reg + 2'h1 : slot_reg;
        end
    end

    // sinks: bus A serves modules 0-3, bus B modules 4-7, one module per slot
    // levels leave as average-current codes; the analog stage pulses at four times them
    generate
        for (gi = 0; gi < 6; gi++) begin : g_sink
            localparam int BASE_IDX = (gi / 3) * 12 + (gi % 3);
            wire [4:0] idx = 5'(BASE_IDX) + {2'h0, slot_reg, 1'b0} + {3'h0, slot_reg};
            always_ff @(posedge i_clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    o_sink_level[gi*12 +: 12] <= 12'h000;
                end else begin
                    o_sink_level[gi*12 +: 12] <= standby ? 12'h000 : level_reg[idx][19:8];
                end
            end
        end
    endgenerate

    wire [3:0] wire_onehot = 4'h1 << slot_reg;

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_wire_en <= 8'h00;
            o_scale   <= `RGBFD_SCALE_FULL;
            o_standby <= 1'b1;
        end else begin
            o_wire_en <= standby ? 8'h00 : {wire_onehot, wire_onehot};
            o_scale   <= scale_reg;
            o_standby <= standby;
        end
    end

endmodule : rgbfd_core

// ===== dv/rgbfd_core_properties.sv
/* Port-level timing checks of the fade and mode core.
   Assumes it is bound to every rgbfd_core instance. */
`timescale 1ns/100ps
module rgbfd_core_properties (
    // clock, reset, register port
    input wire logic        i_clk_sys,
    input wire logic        i_nrst,
    input wire logic        i_reg_wr,
    input wire logic [7:0]  i_reg_addr,
    input wire logic [7:0]  i_reg_wdata,
    input wire logic [7:0]  o_reg_rdata,
    // sink drive
    input wire logic [7:0]  o_wire_en,
    input wire logic [71:0] o_sink_level,
    input wire logic [6:0]  o_scale,
    input wire logic        o_standby
);
    logic [7:0] prev_reg;
    logic [7:0] dwell_reg;
    logic       full_reg;
    wire        moved = o_wire_en != prev_reg;
    wire        unmapped = i_reg_addr < 8'h02 || i_reg_addr > 8'h0C;
    // first slot after wake may be short, so only rotated slots are timed
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            prev_reg  <= 8'h00;
            dwell_reg <= 8'h00;
            full_reg  <= 1'b0;
        end else begin
            prev_reg  <= o_wire_en;
            dwell_reg <= moved ? 8'h00 : dwell_reg + 8'h01;
            full_reg  <= moved ? (prev_reg != 8'h00 && o_wire_en != 8'h00) : full_reg;
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    a_bus_onehot: assert property (o_wire_en[7:4] == o_wire_en[3:0] && $onehot0(o_wire_en[3:0]))
        else $error("wire enables not one slot");
    a_slot_order: assert property (moved && prev_reg != 8'h00 && o_wire_en != 8'h00
        |-> o_wire_en[3:0] == {prev_reg[2:0], prev_reg[3]}) else $error("slot order broken");
    a_slot_dwell: assert property (moved && full_reg && o_wire_en != 8'h00 |-> dwell_reg == 8'h6C)
        else $error("slot length wrong");
    a_standby_dark: assert property (o_standby [*2] |-> o_wire_en == 8'h00 && o_sink_level == 72'h0)
        else $error("outputs on in standby");
    a_standby_scale: assert property (o_standby [*2] |-> o_scale == 7'h40)
        else $error("scale not full in standby");
    a_scale_range: assert property (o_scale >= 7'h10 && o_scale <= 7'h40)
        else $error("scale out of range");
    a_scale_glide: assert property ($changed(o_scale) && !o_standby && !$past(o_standby)
        |-> o_scale == $past(o_scale) + 7'h01 || o_scale == $past(o_scale) - 7'h01) else $error("scale jumped");
    a_wake_bound: assert property (i_reg_wr && i_reg_addr == 8'h02 && i_reg_wdata[7:6] == 2'b10 && o_standby
        |-> ##[1:4] !o_standby) else $error("no wake from standby");
    a_off_drained: assert property ($rose(o_standby) |-> $past(o_sink_level) == 72'h0)
        else $error("standby before drain");
    a_unmapped_zero: assert property (unmapped |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_write_readback: assert property (i_reg_wr && i_reg_addr > 8'h02 && !unmapped ##1 !i_reg_wr
        && $stable(i_reg_addr) |=> o_reg_rdata == $past(i_reg_wdata, 2)) else $error("readback differs");
    a_reg_clear: assert property (i_reg_wr && i_reg_addr == 8'h02 && i_reg_wdata[7:6] == 2'b11
        ##1 i_reg_addr == 8'h02 && !i_reg_wr |=> o_reg_rdata == 8'h00) else $error("control not cleared");
    c_wake: cover property ($fell(o_standby));
    c_drain: cover property ($rose(o_standby));
    c_derate: cover property (o_scale < 7'h40 && !o_standby);
    c_rotate: cover property (moved && full_reg);
endmodule : rgbfd_core_properties

bind rgbfd_core rgbfd_core_properties rgbfd_core_properties_i (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_wire_en(o_wire_en), .o_sink_level(o_sink_level), .o_scale(o_scale), .o_standby(o_standby));

// ===== dv/rgbfd_led_bank.sv
/* Eight RGB modules on two multiplexed buses, reporting sink dropout.
   Assumes the bench raises i_low_supply to starve lit LEDs of headroom. */
`timescale 1ns/100ps
module rgbfd_led_bank (
    input  wire logic        i_clk_sys,
    input  wire logic        i_low_supply,
    input  wire logic [7:0]  i_wire_en,
    input  wire logic [71:0] i_sink_level,
    output logic             o_dropout
);
    // pulse is four times the code, so any lit sink needs headroom
    wire lit = i_wire_en != 8'h00 && i_sink_level != 72'h0;
    initial o_dropout = 1'b0;
    always @(posedge i_clk_sys) o_dropout <= i_low_supply && lit;
endmodule : rgbfd_led_bank

// ===== dv/rgbfd_core_tb.sv
/* Bench of the fade and mode core: registers, fades, modes, scaling.
   Assumes a 10 MHz clock and a shortened fade tick. */
`timescale 1ns/100ps
module rgbfd_core_tb;
    logic        i_clk_sys = 1'b0;
    logic        i_nrst = 1'b0;
    logic        i_reg_wr = 1'b0;
    logic [7:0]  i_reg_addr = 8'h00;
    logic [7:0]  i_reg_wdata = 8'h00;
    logic [3:0]  i_temp_over = 4'h0;
    logic        low_supply = 1'b0;
    logic        i_dropout;
    logic [7:0]  o_reg_rdata;
    logic [7:0]  o_wire_en;
    logic [71:0] o_sink_level;
    logic [6:0]  o_scale;
    logic        o_standby;
    logic [71:0] got;
    logic [6:0]  held;
    int          n_errors = 0;
    int          cmp_count = 0;

    always #50 i_clk_sys = ~i_clk_sys;

    rgbfd_core #(.P_TICK_BASE(20'h00004)) rgbfd_core_i (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
        .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .i_dropout(i_dropout), .i_temp_over(i_temp_over), .o_wire_en(o_wire_en),
        .o_sink_level(o_sink_level), .o_scale(o_scale), .o_standby(o_standby));
    rgbfd_led_bank rgbfd_led_bank_i (.i_clk_sys(i_clk_sys), .i_low_supply(low_supply),
        .i_wire_en(o_wire_en), .i_sink_level(o_sink_level), .o_dropout(i_dropout));

    task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
        #10;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc(1);
        i_reg_wr = 1'b1;
        i_reg_addr = a;
        i_reg_wdata = d;
        cyc(1);
        i_reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        cyc(1);
        i_reg_addr = a;
        cyc(2);
        got = {64'h0, o_reg_rdata};
    endtask : rd
    // waits for slot k of bus A, then takes the lagged sink codes
    task automatic slot(input int k);
        int n;
        n = 0;
        while (o_wire_en[3:0] !== 4'(1 << k) && n < 600) begin
            cyc(1);
            n++;
        end
        cyc(2);
        got = o_sink_level;
    endtask : slot
    task automatic t_reset();
        chk(o_standby, 1);
        chk(o_wire_en, 0);
        chk(o_scale, 7'h40);
        rd(8'h02);
        chk(got, 0);
    endtask : t_reset
    task automatic t_regs();
        for (int i = 0; i < 6; i++) wr(8'(8'h03 + i), 8'(8'h10 * (i + 1)));
        wr(8'h09, 8'h8D);
        wr(8'h0B, 8'h0F);
        for (int i = 0; i < 6; i++) begin
            rd(8'(8'h03 + i));
            chk(got, 72'(8'h10 * (i + 1)));
        end
        rd(8'h0D);
        chk(got, 0);
        rd(8'hFF);
        chk(got, 0);
        chk(o_standby, 1);
    endtask : t_regs
    task automatic t_normal();
        wr(8'h02, 8'h80);
        rd(8'h02);
        chk(got, 72'h80);
        cyc(6000);
        slot(0);
        chk(got, {36'h0, 12'h300, 12'h200, 12'h100});
        slot(1);
        chk(got, {12'h600, 12'h500, 12'h400, 12'h600, 12'h200, 12'h400});
        chk(o_wire_en, 8'h22);
        slot(2);
        chk(got, 0);
    endtask : t_normal
    task automatic t_night();
        wr(8'h02, 8'h40);
        cyc(40);
        slot(0);
        chk(got[11:0] > 12'h010 && got[11:0] < 12'h100, 1);
        cyc(6000);
        slot(0);
        chk(got, {36'h0, 12'h030, 12'h020, 12'h010});
    endtask : t_night
    task automatic t_scale();
        wr(8'h02, 8'hA0);
        low_supply = 1'b1;
        cyc(8100);
        chk(o_scale < 7'h40, 1);
        held = o_scale;
        low_supply = 1'b0;
        cyc(16100);
        chk(o_scale > held, 1);
        wr(8'h02, 8'h88);
        i_temp_over = 4'h2;
        held = o_scale;
        cyc(8100);
        chk(o_scale < held, 1);
    endtask : t_scale
    task automatic t_off();
        int n;
        i_temp_over = 4'h0;
        wr(8'h02, 8'h07);
        cyc(10);
        chk(o_standby, 0);
        cyc(3000);
        chk(o_standby, 0);
        wr(8'h02, 8'h00);
        n = 0;
        while (o_standby !== 1'b1 && n < 8000) begin
            cyc(1);
            n++;
        end
        chk(o_standby, 1);
        cyc(3);
        chk(o_scale, 7'h40);
        chk(o_wire_en, 0);
        rd(8'h03);
        chk(got, 72'h10);
    endtask : t_off
    task automatic t_clear();
        wr(8'h02, 8'hC0);
        rd(8'h02);
        chk(got, 0);
        rd(8'h05);
        chk(got, 0);
        rd(8'h09);
        chk(got, 0);
    endtask : t_clear
    task automatic wrap_up();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    initial begin
        #8500000;
        n_errors++;
        wrap_up();
    end
    initial begin
        cyc(12);
        i_nrst = 1'b1;
        cyc(2);
        t_reset();
        t_regs();
        t_normal();
        t_night();
        t_scale();
        t_off();
        t_clear();
        wrap_up();
    end
endmodule : rgbfd_core_tb
